// file: design/jtm_pkg.sv
// Shared constants, types and lane packing functions for the transport lane mapper
package jtm_pkg;

    localparam int NUM_LANES = 8;
    localparam int LANE_BITS = 64;
    localparam int NUM_CHANS = 4;
    localparam int MAX_SAMPLES = 20;
    localparam int SAMPLE_BITS = 9;
    localparam int MAX_SLOTS = 5;
    localparam int FRAME_COUNT_BITS = 16;

    // Link format codes as written to link_format_select
    localparam logic [3:0] FMT_9B_8B10B_FIVE = 4'hb;
    localparam logic [3:0] FMT_8B_64B_OCTET = 4'hc;
    localparam logic [3:0] FMT_9B_8B10B_FOUR = 4'hd;
    localparam logic [3:0] FMT_9B_64B_PAIR = 4'he;
    localparam logic [3:0] FMT_9B_64B_EIGHT = 4'hf;
    localparam logic [3:0] FMT_RESET = 4'hb;

    localparam logic [3:0] TAIL_NIBBLE = 4'h0;
    localparam logic [3:0] TAIL_POS = 4'h0;
    localparam logic [1:0] BUF_DEPTH = 2'h2;

    localparam logic [7:0] MASK_NONE = 8'h00;
    localparam logic [7:0] MASK_TWO = 8'h03;
    localparam logic [7:0] MASK_FOUR = 8'h0f;
    localparam logic [7:0] MASK_EIGHT = 8'hff;

    typedef enum logic [1:0] {
        JTM_SINGLE,
        JTM_DUAL,
        JTM_QUAD
    } jtm_chans_t;

    typedef logic [NUM_CHANS-1:0][MAX_SAMPLES-1:0][SAMPLE_BITS-1:0] jtm_samples_t;
    typedef logic [NUM_LANES-1:0][LANE_BITS-1:0] jtm_lanes_t;

    typedef struct packed {
        logic valid;
        logic [2:0] lanes_per_chan;
        logic [2:0] slots;
        logic [3:0] slot_bits;
        logic [3:0] data_bits;
        logic tail;
    } jtm_geom_t;

    function automatic jtm_geom_t fmt_geom(logic [3:0] fmt);
        jtm_geom_t g;
        g = '0;
        case (fmt)
            FMT_9B_8B10B_FIVE: g = '{1'b1, 3'h4, 3'h5, 4'hc, 4'h9, 1'b1};
            FMT_8B_64B_OCTET: g = '{1'b1, 3'h4, 3'h1, 4'h8, 4'h8, 1'b0};
            FMT_9B_8B10B_FOUR: g = '{1'b1, 3'h4, 3'h4, 4'ha, 4'h9, 1'b0};
            FMT_9B_64B_PAIR: g = '{1'b1, 3'h2, 3'h2, 4'hc, 4'h9, 1'b0};
            FMT_9B_64B_EIGHT: g = '{1'b1, 3'h4, 3'h2, 4'hc, 4'h9, 1'b0};
            default: g = '0;
        endcase
        return g;
    endfunction

    // Lanes driven for a format and channel count
    function automatic logic [7:0] lane_mask(logic [3:0] fmt, jtm_chans_t ch);
        logic [7:0] m;
        m = MASK_NONE;
        if (fmt == FMT_9B_64B_PAIR) begin
            case (ch)
                JTM_SINGLE: m = MASK_TWO;
                JTM_DUAL: m = MASK_FOUR;
                JTM_QUAD: m = MASK_EIGHT;
                default: m = MASK_NONE;
            endcase
        end else if (fmt_geom(fmt).valid) begin
            case (ch)
                JTM_SINGLE: m = MASK_FOUR;
                JTM_DUAL: m = MASK_EIGHT;
                default: m = MASK_NONE;
            endcase
        end
        return m;
    endfunction

    // Slots are left aligned from octet 0; pad bits fall out as zeros
    function automatic logic [LANE_BITS-1:0] pack_lane(jtm_geom_t g, jtm_samples_t smp, int lane);
        logic [LANE_BITS-1:0] word;
        logic [SAMPLE_BITS-1:0] s;
        logic [LANE_BITS-1:0] slot;
        int lpc;
        int ch;
        int loc;
        word = '0;
        lpc = (g.lanes_per_chan == 3'h0) ? 1 : int'(g.lanes_per_chan);
        ch = lane / lpc;
        loc = lane % lpc;
        for (int k = 0; k < MAX_SLOTS; k++) begin
            if (g.valid && k < int'(g.slots)) begin
                s = smp[ch][loc + k * lpc];
                slot = (g.data_bits == 4'h8) ? {s[8:1], 56'h0} : {s, 55'h0};
                word = word | (slot >> (k * int'(g.slot_bits)));
            end
        end
        if (g.tail) begin
            word[TAIL_POS +: 4] = TAIL_NIBBLE;
        end
        return word;
    endfunction

    function automatic logic [SAMPLE_BITS-1:0] unpack_slot(jtm_geom_t g, logic [LANE_BITS-1:0] word, int k);
        logic [LANE_BITS-1:0] sh;
        sh = word << (k * int'(g.slot_bits));
        return (g.data_bits == 4'h8) ? {sh[63:56], 1'b0} : sh[63:55];
    endfunction

endpackage

// file: design/jtm_link_if.sv
// Lane frame carrier between the mapping end and the receiving end
`timescale 1ns/1ps
interface jtm_link_if;
    jtm_pkg::jtm_lanes_t lane_data;
    logic [7:0] lane_en;
    logic valid;
    logic ready;

    modport tx (
        output lane_data,
        output lane_en,
        output valid,
        input ready
    );

    modport rx (
        input lane_data,
        input lane_en,
        input valid,
        output ready
    );
endinterface

// file: design/jtm_mapper_tx.sv
// Converter end: maps channel samples onto lane frames through a two-entry buffer
`timescale 1ns/1ps

module jtm_mapper_tx (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic link_enable_i,
    input wire logic [3:0] link_format_select_i,
    input wire jtm_pkg::jtm_chans_t chan_count_i,
    input wire logic samples_valid_i,
    input wire jtm_pkg::jtm_samples_t samples_i,
    output logic samples_ready_o,
    output logic format_pending_o,
    output logic format_bad_o,
    output logic [15:0] frames_sent_o,
    jtm_link_if.tx link
);

    typedef struct packed {
        logic [3:0] fmt;
        jtm_pkg::jtm_chans_t chans;
        logic fmt_bad;
        logic fmt_pending;
        logic in_ready;
        logic out_valid;
        logic [1:0] count;
        logic [7:0] lane_en;
        jtm_pkg::jtm_lanes_t head;
        jtm_pkg::jtm_lanes_t tail;
        logic [15:0] frames;
    } jtm_tx_state_t;

    localparam jtm_tx_state_t TX_RESET = '{
        fmt: jtm_pkg::FMT_RESET,
        chans: jtm_pkg::JTM_SINGLE,
        default: '0
    };

    jtm_tx_state_t s;
    jtm_tx_state_t next_s;
    jtm_pkg::jtm_geom_t geom;
    jtm_pkg::jtm_lanes_t words;
    logic [7:0] mask;
    logic push;
    logic pop;

    always_comb begin
        next_s = s;
        geom = jtm_pkg::fmt_geom(s.fmt);
        mask = jtm_pkg::lane_mask(s.fmt, s.chans);
        push = samples_valid_i && s.in_ready;
        pop = s.out_valid && link.ready;

        // Idle lanes carry zeros so a stale word never leaks out
        for (int l = 0; l < jtm_pkg::NUM_LANES; l++) begin
            words[l] = mask[l] ? jtm_pkg::pack_lane(geom, samples_i, l) : '0;
        end

        // Head is the output register; tail only fills when the receiver stalls
        case (s.count)
            2'h0: begin
                if (push) begin
                    next_s.head = words;
                    next_s.count = 2'h1;
                end
            end
            2'h1: begin
                if (push && pop) begin
                    next_s.head = words;
                end else if (pop) begin
                    next_s.count = 2'h0;
                end else if (push) begin
                    next_s.tail = words;
                    next_s.count = 2'h2;
                end
            end
            2'h2: begin
                if (pop) begin
                    next_s.head = s.tail;
                    next_s.count = 2'h1;
                end
            end
            default: begin
                next_s.count = 2'h0;
            end
        endcase

        if (pop) begin
            next_s.frames = s.frames + 16'h1;
        end

        // Packing can only change while the link is disabled, which also empties the buffer
        if (!link_enable_i) begin
            next_s.fmt = link_format_select_i;
            next_s.chans = chan_count_i;
            next_s.fmt_pending = 1'b0;
            next_s.count = 2'h0;
            next_s.fmt_bad = (jtm_pkg::lane_mask(link_format_select_i, chan_count_i) == jtm_pkg::MASK_NONE);
        end else begin
            // A request made while running is held off, not applied
            next_s.fmt_pending = (link_format_select_i != s.fmt) || (chan_count_i != s.chans);
        end

        next_s.lane_en = link_enable_i ? mask : jtm_pkg::MASK_NONE;
        next_s.out_valid = (next_s.count != 2'h0);
        next_s.in_ready = link_enable_i && !next_s.fmt_bad && (next_s.count != jtm_pkg::BUF_DEPTH);
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= TX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign samples_ready_o = s.in_ready;
    assign format_pending_o = s.fmt_pending;
    assign format_bad_o = s.fmt_bad;
    assign frames_sent_o = s.frames;
    assign link.lane_data = s.head;
    assign link.lane_en = s.lane_en;
    assign link.valid = s.out_valid;

endmodule

// file: design/jtm_mapper_rx.sv
// Receiving end: inverse lane mapping back to channel samples
`timescale 1ns/1ps
module jtm_mapper_rx (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic link_enable_i,
    input wire logic [3:0] link_format_select_i,
    input wire jtm_pkg::jtm_chans_t chan_count_i,
    input wire logic samples_ready_i,
    output logic samples_valid_o,
    output jtm_pkg::jtm_samples_t samples_o,
    output logic pad_error_o,
    output logic lane_error_o,
    jtm_link_if.rx link
);

    typedef struct packed {
        logic [3:0] fmt;
        jtm_pkg::jtm_chans_t chans;
        logic link_ready;
        logic out_valid;
        logic pad_error;
        logic lane_error;
        jtm_pkg::jtm_samples_t samples;
    } jtm_rx_state_t;

    localparam jtm_rx_state_t RX_RESET = '{
        fmt: jtm_pkg::FMT_RESET,
        chans: jtm_pkg::JTM_SINGLE,
        default: '0
    };

    jtm_rx_state_t s;
    jtm_rx_state_t next_s;
    jtm_pkg::jtm_geom_t geom;
    jtm_pkg::jtm_samples_t smp;
    logic [7:0] mask;
    logic take;
    logic bad_pad;
    int lpc;

    always_comb begin
        next_s = s;
        geom = jtm_pkg::fmt_geom(s.fmt);
        mask = jtm_pkg::lane_mask(s.fmt, s.chans);
        lpc = (geom.lanes_per_chan == 3'h0) ? 1 : int'(geom.lanes_per_chan);
        take = link.valid && s.link_ready;
        smp = '0;
        bad_pad = 1'b0;

        for (int l = 0; l < jtm_pkg::NUM_LANES; l++) begin
            for (int k = 0; k < jtm_pkg::MAX_SLOTS; k++) begin
                if (mask[l] && k < int'(geom.slots)) begin
                    smp[l / lpc][(l % lpc) + k * lpc] = jtm_pkg::unpack_slot(geom, link.lane_data[l], k);
                end
            end
        end
        // Repacking exposes any nonzero pad or tail bit
        for (int l = 0; l < jtm_pkg::NUM_LANES; l++) begin
            if (mask[l] && jtm_pkg::pack_lane(geom, smp, l) != link.lane_data[l]) begin
                bad_pad = 1'b1;
            end
        end

        if (s.out_valid && samples_ready_i) begin
            next_s.out_valid = 1'b0;
        end
        if (take) begin
            next_s.samples = smp;
            next_s.out_valid = 1'b1;
            next_s.pad_error = bad_pad;
            next_s.lane_error = (link.lane_en != mask);
        end
        if (!link_enable_i) begin
            next_s.fmt = link_format_select_i;
            next_s.chans = chan_count_i;
        end
        // Single output register: accepts only when empty, halving peak rate
        next_s.link_ready = link_enable_i && !next_s.out_valid;
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s <= RX_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign samples_valid_o = s.out_valid;
    assign samples_o = s.samples;
    assign pad_error_o = s.pad_error;
    assign lane_error_o = s.lane_error;
    assign link.ready = s.link_ready;

endmodule

// file: testbench/jtm_link_sva.sv
// Checks on the lane link between the two mapper ends
`timescale 1ns/1ps
module jtm_link_sva (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire logic link_enable_i,
    input wire logic [3:0] link_format_select_i,
    input wire jtm_pkg::jtm_lanes_t lane_data,
    input wire logic [7:0] lane_en,
    input wire logic valid,
    input wire logic ready
);
    logic [3:0] fmt;
    logic [63:0] d0;
    assign d0 = lane_data[0];
    // Mirrors the latch, so a request made while enabled is ignored
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fmt <= jtm_pkg::FMT_RESET;
        end else if (!link_enable_i) begin
            fmt <= link_format_select_i;
        end
    end
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    chk_tail_zero: assert property (valid && fmt == jtm_pkg::FMT_9B_8B10B_FIVE |->
        d0[54:52] == 3'h0 && d0[3:0] == 4'h0) else $error("five slot pad not zero");
    chk_octet_only: assert property (valid && fmt == jtm_pkg::FMT_8B_64B_OCTET |->
        d0[55:0] == 56'h0) else $error("octet lane has bits below the octet");
    chk_ten_bit: assert property (valid && fmt == jtm_pkg::FMT_9B_8B10B_FOUR |->
        d0[54] == 1'b0 && d0[23:0] == 24'h0) else $error("ten bit slot pad not zero");
    chk_pair_pad: assert property (valid && fmt == jtm_pkg::FMT_9B_64B_PAIR |->
        d0[42:40] == 3'h0 && d0[39:0] == 40'h0) else $error("lane pair pad not zero");
    chk_eight_pad: assert property (valid && fmt == jtm_pkg::FMT_9B_64B_EIGHT |->
        lane_en[3:0] == 4'hf && d0[39:0] == 40'h0) else $error("eight sample lane wrong");
    chk_pair_mask: assert property (valid && fmt == jtm_pkg::FMT_9B_64B_PAIR |->
        lane_en inside {8'h03, 8'h0f, 8'hff}) else $error("lane pair mask illegal");
    chk_quiet_off: assert property (!link_enable_i ##1 !link_enable_i |->
        lane_en == 8'h00 && !valid) else $error("lanes driven while link off");
    chk_held_frame: assert property (valid && !ready && link_enable_i |=>
        !link_enable_i || (valid && $stable(lane_data) && $stable(lane_en))) else $error("frame changed while stalled");
    cov_take: cover property (valid && ready);
    cov_stall: cover property (valid && !ready ##1 valid && !ready);
    cov_single_pair: cover property (valid && lane_en == 8'h03);
endmodule

// file: testbench/jtm_mapper_tb.sv
// Both mapper ends joined back to back, driven from the user sides, judged at the link lanes and the user sides
`timescale 1ns/1ps
module jtm_transport_lane_mapper_tb;
    logic clock_i, rst_b_i, en, usr_rdy, s_valid, s_ready, pend, bad, r_valid, pad_err, lane_err;
    logic [3:0] fmt_sel;
    logic [15:0] nsent;
    jtm_pkg::jtm_chans_t chans;
    jtm_pkg::jtm_samples_t smp, r_smp;
    int n_fail, tests_run, lpc, ns, w;
    jtm_link_if jtm_link_if_inst();
    jtm_mapper_tx jtm_mapper_tx_inst(.clock_i(clock_i), .rst_b_i(rst_b_i), .link_enable_i(en),
        .link_format_select_i(fmt_sel), .chan_count_i(chans), .samples_valid_i(s_valid), .samples_i(smp),
        .samples_ready_o(s_ready), .format_pending_o(pend), .format_bad_o(bad), .frames_sent_o(nsent),
        .link(jtm_link_if_inst.tx));
    jtm_mapper_rx jtm_mapper_rx_inst(.clock_i(clock_i), .rst_b_i(rst_b_i), .link_enable_i(en),
        .link_format_select_i(fmt_sel), .chan_count_i(chans), .samples_ready_i(usr_rdy),
        .samples_valid_o(r_valid), .samples_o(r_smp), .pad_error_o(pad_err), .lane_error_o(lane_err),
        .link(jtm_link_if_inst.rx));
    jtm_link_sva jtm_link_sva_inst(.clock_i(clock_i), .rst_b_i(rst_b_i), .link_enable_i(en),
        .link_format_select_i(fmt_sel), .lane_data(jtm_link_if_inst.lane_data),
        .lane_en(jtm_link_if_inst.lane_en), .valid(jtm_link_if_inst.valid), .ready(jtm_link_if_inst.ready));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task report_and_stop();
        $display("TB: %0d mismatches in %0d checks", n_fail, tests_run);
        if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [719:0] seen, input logic [719:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Odd offsets keep the low bit busy, so a dropped LSB shows
    function automatic logic [8:0] sv(int c, int n, int base);
        return 9'(c * 77 + n * 5 + base);
    endfunction
    function automatic logic [7:0] mask_of(logic [3:0] code, jtm_pkg::jtm_chans_t ch);
        if (code == 4'he) return (ch == jtm_pkg::JTM_SINGLE) ? 8'h03 : (ch == jtm_pkg::JTM_DUAL) ? 8'h0f : 8'hff;
        return (ch == jtm_pkg::JTM_SINGLE) ? 8'h0f : 8'hff;
    endfunction
    task set_fmt(input logic [3:0] code, input jtm_pkg::jtm_chans_t ch);
        en <= 1'b0;
        fmt_sel <= code;
        chans <= ch;
        lpc = (code == 4'he) ? 2 : 4;
        case (code)
            4'hb: begin ns = 5; w = 12; end
            4'hc: begin ns = 1; w = 8; end
            4'hd: begin ns = 4; w = 10; end
            default: begin ns = 2; w = 12; end
        endcase
        repeat (2) @(posedge clock_i);
        en <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask
    // Ready is read at the falling edge, so the take edge is never raced
    task put(input int base, input bit must, output bit ok);
        for (int c = 0; c < 4; c++) for (int n = 0; n < 20; n++) smp[c][n] <= sv(c, n, base);
        s_valid <= 1'b1;
        ok = 1'b0;
        for (int i = 0; i < 8 && !ok; i++) begin
            @(negedge clock_i);
            ok = (s_ready === 1'b1);
            @(posedge clock_i);
        end
        s_valid <= 1'b0;
        if (must && !ok) begin
            n_fail++;
            report_and_stop();
        end
    endtask
    task wait_for(input bit on_link);
        for (int i = 0; i <= 20; i++) begin
            @(negedge clock_i);
            if ((on_link ? jtm_link_if_inst.valid : r_valid) === 1'b1) return;
        end
        n_fail++;
        report_and_stop();
    endtask
    task see_lanes(input int base, input logic [7:0] m);
        logic [63:0] r;
        wait_for(1'b1);
        chk(720'(jtm_link_if_inst.lane_en), 720'(m));
        for (int l = 0; l < 8; l++) if (m[l]) begin
            r = '0;
            for (int k = 0; k < ns; k++)
                if (w == 8) r[63 -: 8] = 8'(sv(l / lpc, l % lpc, base) >> 1);
                else r[63 - k * w -: 9] = sv(l / lpc, l % lpc + k * lpc, base);
            chk(720'(jtm_link_if_inst.lane_data[l]), 720'(r));
        end
    endtask
    task get(input int base, input int nch);
        jtm_pkg::jtm_samples_t e;
        e = '0;
        for (int c = 0; c < nch; c++) for (int n = 0; n < lpc * ns; n++)
            e[c][n] = (w == 8) ? (sv(c, n, base) & 9'h1fe) : sv(c, n, base);
        wait_for(1'b0);
        chk(r_smp, e);
        chk(720'({pad_err, lane_err}), 720'(0));
        // Drain request is driven on the rising edge, samples still stand
        @(posedge clock_i);
        usr_rdy <= 1'b1;
        @(posedge clock_i);
        usr_rdy <= 1'b0;
    endtask
    task automatic t_formats();
        logic [3:0] codes[7] = '{4'hb, 4'hc, 4'hd, 4'he, 4'hf, 4'he, 4'he};
        jtm_pkg::jtm_chans_t chs[7] = '{jtm_pkg::JTM_DUAL, jtm_pkg::JTM_DUAL, jtm_pkg::JTM_DUAL,
            jtm_pkg::JTM_QUAD, jtm_pkg::JTM_SINGLE, jtm_pkg::JTM_SINGLE, jtm_pkg::JTM_DUAL};
        bit ok;
        for (int i = 0; i < 7; i++) begin
            set_fmt(codes[i], chs[i]);
            put(i + 3, 1'b1, ok);
            see_lanes(i + 3, mask_of(codes[i], chs[i]));
            get(i + 3, $countones(mask_of(codes[i], chs[i])) / lpc);
        end
    endtask
    // A stalled receiver must cost no frame, only refusals
    task t_stall();
        int acc;
        logic [15:0] n0;
        bit ok;
        set_fmt(4'hf, jtm_pkg::JTM_DUAL);
        n0 = nsent;
        acc = 0;
        for (int i = 0; i < 4; i++) begin
            put(20 + i, 1'b0, ok);
            if (ok) acc++;
            @(posedge clock_i);
        end
        chk(720'(acc >= 2 && acc < 4), 720'(1));
        for (int i = 0; i < acc; i++) get(20 + i, 2);
        repeat (3) @(posedge clock_i);
        chk(720'(nsent - n0), 720'(acc));
    endtask
    task t_change_live();
        bit ok;
        set_fmt(4'hb, jtm_pkg::JTM_DUAL);
        fmt_sel <= 4'hc;
        repeat (2) @(posedge clock_i);
        chk(720'(pend), 720'(1));
        put(40, 1'b1, ok);
        see_lanes(40, 8'hff);
        get(40, 2);
        set_fmt(4'hb, jtm_pkg::JTM_QUAD);
        chk(720'({bad, s_ready}), 720'(2));
    endtask
    initial begin
        {rst_b_i, en, usr_rdy, s_valid, n_fail, tests_run} = '0;
        fmt_sel = jtm_pkg::FMT_RESET;
        chans = jtm_pkg::JTM_SINGLE;
        smp = '0;
        repeat (2) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        t_formats();
        t_stall();
        t_change_live();
        report_and_stop();
    end
endmodule
